// >>> src/psc_fifo.sv
// Purpose: Flip-flop FIFO with valid/ready on both sides.
// Assumes: Single clock, synchronous active high reset.
// Notes: Full and empty are exact; depth a power of two.
`timescale 1ns/1ps
module psc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Fill side
    input wire logic IN_VALID,
    output logic IN_READY,
    input wire logic [WIDTH-1:0] IN_DATA,
    // Drain side
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [WIDTH-1:0] OUT_DATA
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    assign IN_READY = (count_ff != (AW+1)'(DEPTH));
    assign OUT_VALID = (count_ff != '0);
    assign OUT_DATA = mem_ff[rd_ptr_ff];
    assign push = IN_VALID && IN_READY;
    assign pop = OUT_VALID && OUT_READY;

    always_ff @(posedge CLK) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= IN_DATA;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + AW'(1);
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : psc_fifo

// >>> src/psc_pkg.sv
// Purpose: Types for the pipelined burst memory control port.
// Assumes: Default widths from psc_regs.svh.
// Notes: Command carrier is decoded on a qualified edge; addr is kept only on a load.
`include "psc_regs.svh"
package psc_pkg;
    typedef enum logic [1:0] {PSC_IDLE, PSC_READ, PSC_WRITE} psc_op_type;
    typedef struct packed {
        logic [`PSC_ADDR_W-1:0] addr;
        logic [`PSC_LANES-1:0] byte_write_select_n;
        logic write_n;
        logic advance_load;
        logic chip_select_first_n;
        logic chip_select_second;
        logic chip_select_third_n;
    } psc_cmd_type;
    typedef struct packed {
        logic [`PSC_ADDR_W-1:0] addr;
        logic [`PSC_LANES-1:0] lane_we;
        logic [`PSC_LANES*`PSC_BYTE_W-1:0] data;
    } psc_wr_type;
endpackage : psc_pkg

// >>> src/psc_port.sv
// Purpose: Synchronous command and data port of a pipelined burst memory.
// Assumes: Pins already synchronous to CLK; controller keeps its side.
// Notes: Writes are queued to a FIFO toward the storage array.
`timescale 1ns/1ps
module psc_port
    import psc_pkg::*;
#(
    parameter int ADDR_W = `PSC_ADDR_W,
    parameter int LANES = `PSC_LANES,
    parameter int BYTE_W = `PSC_BYTE_W,
    parameter int FIFO_DEPTH = `PSC_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Command pins
    input wire psc_cmd_type CMD,
    input wire logic CLOCK_QUALIFY_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic BURST_ORDER_STRAP,
    // Data and parity lanes
    input wire logic [LANES*BYTE_W-1:0] DQ_IN,
    output logic [LANES*BYTE_W-1:0] DQ_OUT,
    output logic [LANES-1:0] DQ_OE,
    // Read data from storage array
    input wire logic [LANES*BYTE_W-1:0] ARRAY_RDATA,
    output logic [ADDR_W-1:0] ARRAY_RADDR,
    // Write queue toward storage array
    output logic WR_VALID,
    input wire logic WR_READY,
    output psc_wr_type WR_DATA,
    output logic WR_OVERFLOW
);
    logic qual;
    logic sel;
    logic [1:0] burst_ff;
    logic [ADDR_W-1:0] base_ff;
    logic interleave_ff;
    logic strap_taken_ff;
    psc_op_type op_ff;
    psc_op_type op_d1_ff;
    logic [ADDR_W-1:0] addr_d1_ff;
    logic [LANES-1:0] bwn_d1_ff;
    logic first_after_desel_ff;
    logic was_desel_ff;
    logic [LANES*BYTE_W-1:0] rdata_ff;
    logic drive_ff;
    logic [1:0] nxt_burst;
    logic [ADDR_W-1:0] cur_addr;
    psc_op_type nxt_op;
    logic fifo_in_ready;
    logic wr_push;

    assign qual = !CLOCK_QUALIFY_N;
    assign sel = !CMD.chip_select_first_n && CMD.chip_select_second
        && !CMD.chip_select_third_n;

    // Strap caught once after reset; must stay static
    always_ff @(posedge CLK) begin
        if (RST) begin
            strap_taken_ff <= 1'b0;
            interleave_ff <= `PSC_MODE_INTERLEAVED;
        end else if (!strap_taken_ff) begin
            strap_taken_ff <= 1'b1;
            interleave_ff <= BURST_ORDER_STRAP;
        end
    end

    // Address of the next burst beat from loaded base
    always_comb begin
        nxt_burst = burst_ff + 2'd1;
        if (interleave_ff) begin
            cur_addr = {base_ff[ADDR_W-1:2], base_ff[1:0] ^ nxt_burst};
        end else begin
            cur_addr = {base_ff[ADDR_W-1:2], base_ff[1:0] + nxt_burst};
        end
    end

    // Next operation from command
    always_comb begin
        nxt_op = op_ff;
        if (!sel) begin
            nxt_op = PSC_IDLE;
        end else if (!CMD.advance_load) begin
            nxt_op = CMD.write_n ? PSC_READ : PSC_WRITE;
        end // advance keeps op_ff
    end

    // Address and burst state; CLOCK_QUALIFY_N high holds everything
    always_ff @(posedge CLK) begin
        if (RST) begin
            base_ff <= '0;
            burst_ff <= '0;
            op_ff <= PSC_IDLE;
        end else if (qual) begin
            op_ff <= nxt_op;
            if (sel && !CMD.advance_load) begin
                base_ff <= CMD.addr;
                burst_ff <= '0;
            end else if (sel && op_ff != PSC_IDLE) begin
                burst_ff <= nxt_burst;
            end
        end
    end

    // Pipeline stage: command captured, data phase follows
    always_ff @(posedge CLK) begin
        if (RST) begin
            op_d1_ff <= PSC_IDLE;
            addr_d1_ff <= '0;
            bwn_d1_ff <= '1;
            was_desel_ff <= 1'b1;
            first_after_desel_ff <= 1'b0;
        end else if (qual) begin
            op_d1_ff <= nxt_op;
            addr_d1_ff <= (sel && !CMD.advance_load) ? CMD.addr : cur_addr;
            bwn_d1_ff <= CMD.byte_write_select_n;
            was_desel_ff <= (nxt_op == PSC_IDLE);
            first_after_desel_ff <= was_desel_ff && (nxt_op != PSC_IDLE);
        end
    end

    assign ARRAY_RADDR = addr_d1_ff;

    // Write data taken in data phase; lanes gated by selects
    assign wr_push = qual && (op_d1_ff == PSC_WRITE) && (bwn_d1_ff != '1);
    always_ff @(posedge CLK) begin
        if (RST) begin
            WR_OVERFLOW <= 1'b0;
        end else if (wr_push && !fifo_in_ready) begin
            WR_OVERFLOW <= 1'b1; // Sticky: array too slow
        end
    end

    psc_fifo #(
        .WIDTH($bits(psc_wr_type)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .CLK(CLK),
        .RST(RST),
        .IN_VALID(wr_push),
        .IN_READY(fifo_in_ready),
        .IN_DATA({addr_d1_ff, ~bwn_d1_ff, DQ_IN}),
        .OUT_VALID(WR_VALID),
        .OUT_READY(WR_READY),
        .OUT_DATA(WR_DATA)
    );

    // Read data registered; drive only in read data phase
    always_ff @(posedge CLK) begin
        if (RST) begin
            rdata_ff <= '0;
            drive_ff <= 1'b0;
        end else if (qual) begin
            rdata_ff <= ARRAY_RDATA;
            drive_ff <= (op_d1_ff == PSC_READ) && !first_after_desel_ff;
        end
    end

    assign DQ_OUT = rdata_ff;
    assign DQ_OE = {LANES{drive_ff && !OUTPUT_ENABLE_N}};
endmodule : psc_port

// >>> src/psc_regs.svh
// Purpose: Constants for the pipelined burst memory control port.
// Assumes: Included by the package; the port takes the widths and FIFO depth as parameter defaults.
// Notes: Widths are defaults; modules take them as parameters.
`ifndef PSC_REGS_SVH
`define PSC_REGS_SVH
`define PSC_ADDR_W 8
`define PSC_LANES 8
`define PSC_BYTE_W 9
`define PSC_FIFO_DEPTH 16
`define PSC_BURST_LEN 4
`define PSC_MODE_INTERLEAVED 1'b1
`endif

// >>> tb/psc_array_model.sv
// Purpose: Storage array behind the port.
// Assumes: Read is combinational.
// Notes: Stall holds the write queue back.
`timescale 1ns/1ps
module psc_array_model
    import psc_pkg::*;
(
    // Clock
    input wire logic CLK,
    // Storage side
    input wire logic [7:0] RADDR,
    output logic [71:0] RDATA,
    input wire logic WR_VALID,
    output logic WR_READY,
    input wire psc_wr_type WR_DATA,
    input wire logic STALL
);
    logic [71:0] mem [256];
    initial for (int i = 0; i < 256; i++) mem[i] = {9{i[7:0]}};
    assign RDATA = mem[RADDR];
    assign WR_READY = !STALL;
    always @(posedge CLK) begin
        for (int i = 0; i < 8; i++) begin
            if (WR_VALID && WR_READY && WR_DATA.lane_we[i]) mem[WR_DATA.addr][9*i+:9] <= WR_DATA.data[9*i+:9];
        end
    end
endmodule : psc_array_model

// >>> tb/psc_port_properties.sv
// Purpose: Timing checks on the port pins.
// Assumes: Bound to psc_port.
// Notes: Selection decoded here.
`timescale 1ns/1ps
module psc_port_properties
    import psc_pkg::*;
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Pins watched
    input wire psc_cmd_type CMD,
    input wire logic CLOCK_QUALIFY_N,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic [7:0] DQ_OE,
    input wire logic [7:0] ARRAY_RADDR,
    input wire logic WR_VALID,
    input wire logic WR_OVERFLOW
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    wire q = !CLOCK_QUALIFY_N;
    wire sel = !CMD.chip_select_first_n && CMD.chip_select_second && !CMD.chip_select_third_n;
    wire ld = q && sel && !CMD.advance_load;
    AST_OE_GATE: assert property (OUTPUT_ENABLE_N |-> DQ_OE == 8'h00) else $error("oe gate");
    AST_LOAD: assert property (ld |=> ARRAY_RADDR == $past(CMD.addr)) else $error("load addr");
    AST_ADV: assert property (q && CMD.advance_load |=> ARRAY_RADDR[7:2] == $past(ARRAY_RADDR[7:2]))
        else $error("adv page");
    AST_FREEZE: assert property (CLOCK_QUALIFY_N |=> $stable(ARRAY_RADDR)) else $error("freeze");
    AST_WR_OFF: assert property ((ld && !CMD.write_n) ##1 q |=> DQ_OE == 8'h00) else $error("wr drive");
    AST_FIRST_OFF: assert property ((q && !sel) ##1 (ld && CMD.write_n) ##1 q |=> DQ_OE == 8'h00)
        else $error("first drive");
    AST_RD_ON: assert property (ld ##1 (ld && CMD.write_n) ##1 (q && !OUTPUT_ENABLE_N)
        |=> OUTPUT_ENABLE_N || DQ_OE == 8'hFF) else $error("rd drive");
    // Selects travel with the write command, data follows one qualified edge later
    AST_PUSH: assert property ((ld && !CMD.write_n && CMD.byte_write_select_n != 8'hFF) ##1 q
        |-> ##[1:2] (WR_VALID || WR_OVERFLOW)) else $error("no push");
endmodule : psc_port_properties
bind psc_port psc_port_properties psc_port_properties_i (.CLK, .RST, .CMD, .CLOCK_QUALIFY_N,
    .OUTPUT_ENABLE_N, .DQ_OE, .ARRAY_RADDR, .WR_VALID, .WR_OVERFLOW);

// >>> tb/test_pipelined_burst_sram_control_port.sv
// Purpose: Self-checking bench of psc_port.
// Assumes: Array model on the storage side.
// Notes: Both burst orders run.
`timescale 1ns/1ps
module test_pipelined_burst_sram_control_port
    import psc_pkg::*;
;
    logic clk, rst, q_n, oe_n, strap, stall, wv, wr, ovf;
    psc_cmd_type cmd;
    logic [71:0] dq_in, dq_out, rd;
    logic [7:0] oe, ra;
    psc_wr_type wd;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    psc_port psc_port_i (.CLK(clk), .RST(rst), .CMD(cmd), .CLOCK_QUALIFY_N(q_n), .OUTPUT_ENABLE_N(oe_n),
        .BURST_ORDER_STRAP(strap), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(oe), .ARRAY_RDATA(rd),
        .ARRAY_RADDR(ra), .WR_VALID(wv), .WR_READY(wr), .WR_DATA(wd), .WR_OVERFLOW(ovf));
    psc_array_model psc_array_model_i (.CLK(clk), .RADDR(ra), .RDATA(rd), .WR_VALID(wv), .WR_READY(wr),
        .WR_DATA(wd), .STALL(stall));
    initial begin
        clk = 0;
        forever #10 clk = ~clk;
    end
    task test_done;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : test_done
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_errors++;
            test_done;
        end
    end
    task chk(input string n, input logic [71:0] e, input logic [71:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task step(input logic s, input logic w, input logic v, input logic [7:0] a, input logic [7:0] b);
        cmd = {a, b, w, v, !s, s, !s};
        @(posedge clk);
        #1;
    endtask : step
    task t_read(input logic m);
        rst = 1;
        strap = m;
        repeat (16) @(posedge clk);
        #1 rst = 0;
        step(0, 1, 0, 8'h00, 8'hFF);
        step(1, 1, 0, 8'h45, 8'hFF);
        step(1, 1, 0, 8'h45, 8'hFF);
        chk("oe first", 72'h0, 72'(oe));
        step(1, 1, 1, 8'h00, 8'hFF);
        chk("rd", {9{8'h45}}, dq_out);
        chk("oe", 72'hFF, 72'(oe));
        chk("adv", m ? 72'h44 : 72'h46, 72'(ra));
        step(1, 1, 1, 8'h00, 8'hFF);
        chk("rd adv", m ? {9{8'h44}} : {9{8'h46}}, dq_out);
        oe_n = 1;
        #1 chk("oe off", 72'h0, 72'(oe));
        oe_n = 0;
        $display("t_read done");
    endtask : t_read
    task t_write;
        step(1, 0, 0, 8'h10, 8'hFE);
        dq_in = 72'h1A5;
        step(1, 1, 0, 8'h11, 8'hFE);
        dq_in = ~72'h1A5;
        step(1, 1, 0, 8'h11, 8'h00);
        step(1, 1, 0, 8'h11, 8'h00);
        step(1, 1, 0, 8'h10, 8'h00);
        step(1, 1, 1, 8'h00, 8'h00);
        chk("wr lane", {{7{8'h10}}, 7'h08, 9'h1A5}, dq_out);
        chk("no push", 72'h0, 72'(wv));
        $display("t_write done");
    endtask : t_write
    task t_freeze;
        step(1, 1, 0, 8'h20, 8'hFF);
        step(1, 1, 0, 8'h30, 8'hFF);
        q_n = 1;
        step(1, 0, 0, 8'h50, 8'h00);
        step(0, 1, 0, 8'h50, 8'h00);
        chk("frz addr", 72'h30, 72'(ra));
        chk("frz data", {9{8'h20}}, dq_out);
        chk("frz oe", 72'hFF, 72'(oe));
        q_n = 0;
        step(1, 1, 1, 8'h00, 8'hFF);
        chk("thaw", {9{8'h30}}, dq_out);
        chk("frz wr", 72'h0, 72'(wv));
        $display("t_freeze done");
    endtask : t_freeze
    task t_fifo;
        stall = 1;
        step(1, 0, 0, 8'h00, 8'hFF);
        repeat (20) step(1, 0, 1, 8'h00, 8'h00);
        chk("ovf", 72'h1, 72'(ovf));
        stall = 0;
        for (int n = 0; n < 40 && wv !== 1'b0; n++) step(0, 1, 0, 8'h00, 8'hFF);
        chk("drain", 72'h0, 72'(wv));
        $display("t_fifo done");
    endtask : t_fifo
    initial begin
        {rst, q_n, oe_n, strap, stall, dq_in} = {5'b10010, 72'h0};
        cmd = {8'h00, 8'hFF, 5'b10101};
        t_read(1'b1);
        t_write;
        t_freeze;
        t_fifo;
        t_read(1'b0);
        test_done;
    end
endmodule : test_pipelined_burst_sram_control_port
